//--- fprf_defs.svh
`ifndef FPRF_DEFS_SVH
`define FPRF_DEFS_SVH

// storage geometry: 64 words of 32 bits carry every alias view
`define FPRF_NUM_WORDS   64
`define FPRF_WORD_W      32
`define FPRF_DBL_W       64
`define FPRF_QUAD_W      128
`define FPRF_FIELD_W     5
`define FPRF_NUM_W       6
`define FPRF_UPPER_BIT   5

// decoder slots shared through the decode interface
`define FPRF_DEC_PORTS   4
`define FPRF_SLOT_RDA    0
`define FPRF_SLOT_RDB    1
`define FPRF_SLOT_WR     2
`define FPRF_SLOT_ISSUE  3

// trap type field codes
`define FPRF_FTT_W        3
`define FPRF_FTT_NONE     3'h0
`define FPRF_FTT_BAD_REG  3'h6
`define FPRF_FTT_QUAD_EMU 3'h3

// quad operations have no hardware datapath
`define FPRF_QUAD_IN_HW  1'b0

`endif

//--- fprf_pkg.sv
package fprf_pkg;
   // operand size as seen by the register number decode
   typedef enum logic [1:0] {
      FPRF_SZ_SINGLE = 2'b00,
      FPRF_SZ_DOUBLE = 2'b01,
      FPRF_SZ_QUAD   = 2'b10,
      FPRF_SZ_RSVD   = 2'b11
   } fprf_size_e;
endpackage

//--- fprf_dec_if.sv
`include "fprf_defs.svh"

interface fprf_dec_if;
   import fprf_pkg::*;
   logic [`FPRF_FIELD_W-1:0] field      [`FPRF_DEC_PORTS];
   fprf_size_e               size       [`FPRF_DEC_PORTS];
   logic [`FPRF_NUM_W-1:0]   regNum     [`FPRF_DEC_PORTS];
   logic                     isQuad     [`FPRF_DEC_PORTS];
   logic                     misaligned [`FPRF_DEC_PORTS];

   modport user (output field, output size,
                 input regNum, input isQuad, input misaligned);
   modport dec  (input field, input size,
                 output regNum, output isQuad, output misaligned);
endinterface

//--- fprf_decoder.sv
`include "fprf_defs.svh"

module fprf_decoder
   import fprf_pkg::*;
(
   fprf_dec_if.dec dec
);

   ////////////////////////////////////////////////////////////////////////
   // one field-to-number decode per slot
   genvar gi;
   generate
      for (gi = 0; gi < `FPRF_DEC_PORTS; gi++) begin : g_slot
         wire [`FPRF_FIELD_W-1:0] f = dec.field[gi];
         wire [`FPRF_NUM_W-1:0]   numSgl = {1'b0, f};
         wire [`FPRF_NUM_W-1:0]   numDbl = {f[0], f[4:1], 1'b0};
         wire [`FPRF_NUM_W-1:0]   numQd  = {f[0], f[4:2], 2'b00};
         // double decode has a forced zero low bit, never odd
         assign dec.regNum[gi] = (dec.size[gi] == FPRF_SZ_DOUBLE) ? numDbl :
                                 (dec.size[gi] == FPRF_SZ_QUAD)   ? numQd  :
                                                                    numSgl;
         assign dec.isQuad[gi] = (dec.size[gi] == FPRF_SZ_QUAD);
         // quad decode drops field bit 1, so a set bit 1 marks a misaligned quad
         assign dec.misaligned[gi] = dec.isQuad[gi] & f[1];
      end
   endgenerate

endmodule // fprf_decoder

//--- fprf_regfile.sv
`include "fprf_defs.svh"

// Contract
// - 32 singles of 32 bits, numbers 0-31
// - 32 doubles of 64 bits, even numbers
// - 16 quads of 128 bits, multiples of four
// - every register reachable, no banking
// - operate, load/store and block transfers access
// - double N below 32 is singles N, N+1
// - quad is four singles or two doubles
// - single number is field, top bit zero
// - double number: field bit0 on top, zero low
// - quad number: bit0 on top, two zeros low
// - misaligned quad raises bad register trap
// - double decode never yields odd number
// - halves hold any mixture of sizes
// - all quad operations trap for emulation
// - bad register trap never actually raised
// - quad multiply-add also traps, fixed choice
// - upper dirty set on write, software clears
// - lower dirty set on write, software clears
module fprf_regfile
   import fprf_pkg::*;
(
   input  wire logic                     clk_sys,
   input  wire logic                     resetn,
   // read port A
   input  wire logic                     rdAEn,
   input  wire fprf_size_e               rdASize,
   input  wire logic [`FPRF_FIELD_W-1:0] rdAField,
   output logic [`FPRF_QUAD_W-1:0]       rdAData,
   // read port B
   input  wire logic                     rdBEn,
   input  wire fprf_size_e               rdBSize,
   input  wire logic [`FPRF_FIELD_W-1:0] rdBField,
   output logic [`FPRF_QUAD_W-1:0]       rdBData,
   // write port, shared by results, loads and block loads
   input  wire logic                     wrEn,
   input  wire fprf_size_e               wrSize,
   input  wire logic [`FPRF_FIELD_W-1:0] wrField,
   input  wire logic [`FPRF_DBL_W-1:0]   wrData,
   // destination of a newly issued instruction
   input  wire logic                     issueValid,
   input  wire fprf_size_e               issueSize,
   input  wire logic [`FPRF_FIELD_W-1:0] issueField,
   // dirty flags of the register state register
   input  wire logic                     clrUpperDirty,
   input  wire logic                     clrLowerDirty,
   output logic                          upperDirtyFlag,
   output logic                          lowerDirtyFlag,
   // trap report
   output logic                          fpOtherExceptionTrap,
   output logic [`FPRF_FTT_W-1:0]        fpTrapTypeField
);

   ////////////////////////////////////////////////////////////////////////
   // storage and state

   // one flat array of words: single N is word N, double N is words N
   // and N+1, quad N is words N..N+3, so aliasing costs no muxing
   logic [`FPRF_WORD_W-1:0] word_r [`FPRF_NUM_WORDS];
   // read capture flops, one per port
   logic [`FPRF_QUAD_W-1:0] rdAData_r;
   logic [`FPRF_QUAD_W-1:0] rdBData_r;
   // sticky dirty flags of the two halves
   logic                    upperDirty_r;
   logic                    upperDirty_nxt;
   logic                    lowerDirty_r;
   logic                    lowerDirty_nxt;
   // trap pulse and its held type code
   logic                    trap_r;
   logic                    trap_nxt;
   logic [`FPRF_FTT_W-1:0]  ftt_r;
   logic [`FPRF_FTT_W-1:0]  ftt_nxt;

   ////////////////////////////////////////////////////////////////////////
   // register number decode for all four slots

   // one decoder serves all four slots; the interface keeps them in step
   fprf_dec_if decIf ();

   fprf_decoder u_decoder (
      .dec (decIf.dec)
   );

   // slot inputs in the order the slot codes give
   assign decIf.field[`FPRF_SLOT_RDA]   = rdAField;
   assign decIf.size[`FPRF_SLOT_RDA]    = rdASize;
   assign decIf.field[`FPRF_SLOT_RDB]   = rdBField;
   assign decIf.size[`FPRF_SLOT_RDB]    = rdBSize;
   assign decIf.field[`FPRF_SLOT_WR]    = wrField;
   assign decIf.size[`FPRF_SLOT_WR]     = wrSize;
   assign decIf.field[`FPRF_SLOT_ISSUE] = issueField;
   assign decIf.size[`FPRF_SLOT_ISSUE]  = issueSize;

   // decoded six-bit register numbers per slot
   wire [`FPRF_NUM_W-1:0] rdANum = decIf.regNum[`FPRF_SLOT_RDA];
   wire [`FPRF_NUM_W-1:0] rdBNum = decIf.regNum[`FPRF_SLOT_RDB];
   wire [`FPRF_NUM_W-1:0] wrNum  = decIf.regNum[`FPRF_SLOT_WR];
   wire [`FPRF_NUM_W-1:0] issNum = decIf.regNum[`FPRF_SLOT_ISSUE];

   ////////////////////////////////////////////////////////////////////////
   // quad detection: every quad access, fused multiply-add included,
   // goes to the emulation trap instead of the datapath

   logic [`FPRF_DEC_PORTS-1:0] slotEn;
   logic [`FPRF_DEC_PORTS-1:0] slotQuad;
   logic [`FPRF_DEC_PORTS-1:0] slotMis;

   // slot enables in decoder slot order
   assign slotEn[`FPRF_SLOT_RDA]   = rdAEn;
   assign slotEn[`FPRF_SLOT_RDB]   = rdBEn;
   assign slotEn[`FPRF_SLOT_WR]    = wrEn;
   assign slotEn[`FPRF_SLOT_ISSUE] = issueValid;

   // an idle slot never traps, whatever its size code says
   genvar gs;
   generate
      for (gs = 0; gs < `FPRF_DEC_PORTS; gs++) begin : g_qslot
         assign slotQuad[gs] = slotEn[gs] & decIf.isQuad[gs];
         assign slotMis[gs]  = slotQuad[gs] & decIf.misaligned[gs];
      end
   endgenerate

   wire issQuad       = slotQuad[`FPRF_SLOT_ISSUE];
   wire anyQuad       = |slotQuad;
   wire anyMisaligned = |slotMis;

   // bad register only once quads run in hardware; with no quad
   // datapath the emulation trap always comes first
   wire badRegHit = anyMisaligned & `FPRF_QUAD_IN_HW;

   ////////////////////////////////////////////////////////////////////////
   // write decode: a single or double write touches only its own words

   // reserved size codes write nothing, just like quads
   wire wrSingle = wrEn & (wrSize == FPRF_SZ_SINGLE);
   wire wrDouble = wrEn & (wrSize == FPRF_SZ_DOUBLE);
   wire wrTakes  = wrSingle | wrDouble; // quad writes are dropped

   // per-word write enable and write data
   logic [`FPRF_NUM_WORDS-1:0] wordWe;
   logic [`FPRF_WORD_W-1:0]    wordWd [`FPRF_NUM_WORDS];

   genvar gw;
   generate
      for (gw = 0; gw < `FPRF_NUM_WORDS; gw++) begin : g_word
         localparam logic [`FPRF_NUM_W-1:0] IDX = `FPRF_NUM_W'(gw);
         // single hits one word; double hits an even/odd pair
         wire hitSgl = wrSingle & (wrNum == IDX);
         wire hitDbl = wrDouble &
                       (wrNum[`FPRF_NUM_W-1:1] ==
                        IDX[`FPRF_NUM_W-1:1]);
         assign wordWe[gw] = hitSgl | hitDbl;
         // even word takes the high half of a double, odd the low half
         if (gw % 2 == 0) begin : g_even
            assign wordWd[gw] = wrDouble ? wrData[63:32] :
                                           wrData[31:0];
         end else begin : g_odd
            assign wordWd[gw] = wrData[31:0];
         end

         // no reset contents are defined; zero is chosen for determinism
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               word_r[gw] <= 32'h0000_0000;
            end else if (wordWe[gw]) begin
               word_r[gw] <= wordWd[gw];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // read view: one function serves both ports so the alias maps match

   function automatic logic [`FPRF_QUAD_W-1:0] fpView (
      input fprf_size_e             sz,
      input logic [`FPRF_NUM_W-1:0] n
   );
      logic [`FPRF_NUM_W-1:0] n1;
      logic [`FPRF_NUM_W-1:0] n2;
      logic [`FPRF_NUM_W-1:0] n3;
      // the sums wrap in six bits; aligned doubles and quads never
      // reach the wrap, so no carry is needed
      n1 = n + 6'h01;
      n2 = n + 6'h02;
      n3 = n + 6'h03;
      case (sz)
         FPRF_SZ_SINGLE: begin
            fpView = {96'h0000_0000_0000_0000_0000_0000,
                      word_r[n]};
         end
         FPRF_SZ_DOUBLE: begin
            fpView = {64'h0000_0000_0000_0000,
                      word_r[n], word_r[n1]};
         end
         FPRF_SZ_QUAD: begin
            // below 32 four singles, above two doubles; same words
            fpView = {word_r[n], word_r[n1],
                      word_r[n2], word_r[n3]};
         end
         default: begin
            fpView = 128'h0000_0000_0000_0000_0000_0000_0000_0000;
         end
      endcase
   endfunction

   wire [`FPRF_QUAD_W-1:0] rdAView = fpView(rdASize, rdANum);
   wire [`FPRF_QUAD_W-1:0] rdBView = fpView(rdBSize, rdBNum);

   // read data is captured a cycle later; a read in the cycle of a write
   // to the same words returns the old contents
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rdAData_r <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      end else if (rdAEn) begin
         rdAData_r <= rdAView;
      end
   end

   // port B holds its last answer the same way until its next request
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rdBData_r <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      end else if (rdBEn) begin
         rdBData_r <= rdBView;
      end
   end

   // outputs come straight from the capture flops
   assign rdAData = rdAData_r;
   assign rdBData = rdBData_r;

   ////////////////////////////////////////////////////////////////////////
   // dirty flags: set by writes and, pessimistically, by issue

   wire wrUpper  = wrTakes    &  wrNum[`FPRF_UPPER_BIT];
   wire wrLower  = wrTakes    & ~wrNum[`FPRF_UPPER_BIT];
   wire issUpper = issueValid & ~issQuad &  issNum[`FPRF_UPPER_BIT];
   wire issLower = issueValid & ~issQuad & ~issNum[`FPRF_UPPER_BIT];

   // a set in the same cycle as a clear wins so no write is missed
   always_comb begin
      upperDirty_nxt = upperDirty_r;
      lowerDirty_nxt = lowerDirty_r;
      if (clrUpperDirty) upperDirty_nxt = 1'b0;
      if (clrLowerDirty) lowerDirty_nxt = 1'b0;
      if (wrUpper | issUpper) upperDirty_nxt = 1'b1;
      if (wrLower | issLower) lowerDirty_nxt = 1'b1;
   end

   // flags hold until software clears; reset leaves both halves clean
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         upperDirty_r <= 1'b0;
      end else begin
         upperDirty_r <= upperDirty_nxt;
      end
   end

   // lower flag kept apart so each block stays a single register
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         lowerDirty_r <= 1'b0;
      end else begin
         lowerDirty_r <= lowerDirty_nxt;
      end
   end

   // flags leave straight from their flops
   assign upperDirtyFlag = upperDirty_r;
   assign lowerDirtyFlag = lowerDirty_r;

   ////////////////////////////////////////////////////////////////////////
   // trap report: one-cycle pulse with its type code held until the next

   always_comb begin
      trap_nxt = 1'b0;
      ftt_nxt  = ftt_r;
      if (badRegHit) begin
         trap_nxt = 1'b1;
         ftt_nxt  = `FPRF_FTT_BAD_REG;
      end else if (anyQuad) begin
         trap_nxt = 1'b1;
         ftt_nxt  = `FPRF_FTT_QUAD_EMU;
      end
   end

   // the code register keeps the last cause for software to inspect
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         trap_r <= 1'b0;
         ftt_r  <= `FPRF_FTT_NONE;
      end else begin
         trap_r <= trap_nxt;
         ftt_r  <= ftt_nxt;
      end
   end

   // trap pulse and code leave straight from their flops
   assign fpOtherExceptionTrap = trap_r;
   assign fpTrapTypeField      = ftt_r;

endmodule // fprf_regfile

//--- fprf_regfile_chk.sv
`include "fprf_defs.svh"

module fprf_regfile_chk
   import fprf_pkg::*;
(
   input logic         clk_sys,
   input logic         resetn,
   input logic         rdAEn,
   input fprf_size_e   rdASize,
   input logic [127:0] rdAData,
   input logic         rdBEn,
   input fprf_size_e   rdBSize,
   input logic [127:0] rdBData,
   input logic         wrEn,
   input fprf_size_e   wrSize,
   input logic [4:0]   wrField,
   input logic         issueValid,
   input fprf_size_e   issueSize,
   input logic         clrUpperDirty,
   input logic         clrLowerDirty,
   input logic         upperDirtyFlag,
   input logic         lowerDirtyFlag,
   input logic         fpOtherExceptionTrap,
   input logic [2:0]   fpTrapTypeField
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking chkClk @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   // any enabled slot asking for a quad view
   wire quadAny = (rdAEn && rdASize == FPRF_SZ_QUAD)
      || (rdBEn && rdBSize == FPRF_SZ_QUAD)
      || (wrEn && wrSize == FPRF_SZ_QUAD)
      || (issueValid && issueSize == FPRF_SZ_QUAD);

   ////////////////////////////////////////
   // trap path: quads trap one cycle later with the emulation code
   chk_trap_raise: assert property (
      quadAny |=> fpOtherExceptionTrap && fpTrapTypeField == 3'h3)
      else $error("quad access did not trap");
   chk_trap_only: assert property (
      !quadAny |=> !fpOtherExceptionTrap)
      else $error("trap without quad access");
   chk_no_badreg: assert property (
      fpTrapTypeField != `FPRF_FTT_BAD_REG)
      else $error("bad register code produced");
   chk_code_hold: assert property (
      !fpOtherExceptionTrap |-> $stable(fpTrapTypeField))
      else $error("trap code moved without a trap");

   ////////////////////////////////////////
   // dirty flags: set by writes or issues per half, only a clear drops them
   chk_upper_set: assert property (
      wrEn && wrSize == FPRF_SZ_DOUBLE && wrField[0] |=> upperDirtyFlag)
      else $error("upper double write left upper flag low");
   chk_lower_set: assert property (
      issueValid && issueSize == FPRF_SZ_SINGLE |=> lowerDirtyFlag)
      else $error("single issue left lower flag low");
   chk_upper_keep: assert property (
      upperDirtyFlag && !clrUpperDirty |=> upperDirtyFlag)
      else $error("upper flag dropped without clear");
   chk_lower_clear: assert property (
      clrLowerDirty && !wrEn && !issueValid |=> !lowerDirtyFlag)
      else $error("lower flag survived a clear");

   ////////////////////////////////////////
   // read ports
   chk_single_zero: assert property (
      rdBEn && rdBSize == FPRF_SZ_SINGLE |=> rdBData[127:32] == '0)
      else $error("single read has upper bits set");
   chk_rd_hold: assert property (
      !rdAEn |=> $stable(rdAData))
      else $error("read data changed while idle");
endmodule // fprf_regfile_chk

bind fprf_regfile fprf_regfile_chk i_fprf_regfile_chk (
   .clk_sys(clk_sys), .resetn(resetn), .rdAEn(rdAEn),
   .rdASize(rdASize), .rdAData(rdAData), .rdBEn(rdBEn),
   .rdBSize(rdBSize), .rdBData(rdBData), .wrEn(wrEn), .wrSize(wrSize),
   .wrField(wrField), .issueValid(issueValid), .issueSize(issueSize),
   .clrUpperDirty(clrUpperDirty), .clrLowerDirty(clrLowerDirty),
   .upperDirtyFlag(upperDirtyFlag), .lowerDirtyFlag(lowerDirtyFlag),
   .fpOtherExceptionTrap(fpOtherExceptionTrap),
   .fpTrapTypeField(fpTrapTypeField));

//--- fprf_pipe_model.sv
module fprf_pipe_model
   import fprf_pkg::*;
(
   output logic         rdAEn,
   output fprf_size_e   rdASize,
   output logic [4:0]   rdAField,
   output logic         rdBEn,
   output fprf_size_e   rdBSize,
   output logic [4:0]   rdBField,
   output logic         wrEn,
   output fprf_size_e   wrSize,
   output logic [4:0]   wrField,
   output logic [63:0]  wrData,
   output logic         issueValid,
   output fprf_size_e   issueSize,
   output logic [4:0]   issueField,
   output logic         clrUpperDirty,
   output logic         clrLowerDirty
);
   timeunit 1ns;
   timeprecision 100ps;
   int seed = 74;

   // size draw; a limit of 3 keeps issues off the reserved code
   function automatic fprf_size_e pick(int lim);
      return fprf_size_e'(2'({$random(seed)} % lim));
   endfunction

   // one random cycle of pipeline traffic, slots independent
   task automatic randOp();
      rdAEn = 1'($random(seed));
      rdASize = pick(4);
      rdAField = 5'($random(seed));
      rdBEn = 1'($random(seed));
      rdBSize = pick(4);
      rdBField = 5'($random(seed));
      wrEn = 1'($random(seed));
      wrSize = pick(4); // singles fill the lower half
      wrField = 5'($random(seed));
      wrData = {$random(seed), $random(seed)};
      issueValid = 1'($random(seed));
      issueSize = pick(3);
      issueField = 5'($random(seed));
      // clears are rare so the flags get a chance to stay up
      clrUpperDirty = 3'($random(seed)) == 3'h0;
      clrLowerDirty = 3'($random(seed)) == 3'h0;
   endtask

   // defined values at time zero, then quiet until the bench starts
   initial begin
      randOp();
      {rdAEn, rdBEn, wrEn, issueValid, clrUpperDirty, clrLowerDirty} = '0;
   end
endmodule // fprf_pipe_model

//--- test_fprf_regfile.sv
`include "fprf_defs.svh"

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
   errTotal++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
   end end

module test_fprf_regfile
   import fprf_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int NOPS = 3000;

   logic         clk_sys = 1'b0;
   logic         resetn;
   logic         rdAEn, rdBEn, wrEn, issueValid;
   logic         clrUpperDirty, clrLowerDirty;
   fprf_size_e   rdASize, rdBSize, wrSize, issueSize;
   logic [4:0]   rdAField, rdBField, wrField, issueField;
   logic [63:0]  wrData;
   logic [127:0] rdAData, rdBData, mA, mB;
   logic         upperDirtyFlag, lowerDirtyFlag, fpOtherExceptionTrap;
   logic [2:0]   fpTrapTypeField, mCode;
   logic [31:0]  mw [64];
   logic         mU, mL, mTrap;
   int           errTotal = 0;
   int           comparisons = 0;

   always #2 clk_sys = ~clk_sys;

   fprf_regfile i_fprf_regfile (.clk_sys(clk_sys), .resetn(resetn),
      .rdAEn(rdAEn), .rdASize(rdASize), .rdAField(rdAField),
      .rdAData(rdAData), .rdBEn(rdBEn), .rdBSize(rdBSize),
      .rdBField(rdBField), .rdBData(rdBData), .wrEn(wrEn),
      .wrSize(wrSize), .wrField(wrField), .wrData(wrData),
      .issueValid(issueValid), .issueSize(issueSize),
      .issueField(issueField), .clrUpperDirty(clrUpperDirty),
      .clrLowerDirty(clrLowerDirty), .upperDirtyFlag(upperDirtyFlag),
      .lowerDirtyFlag(lowerDirtyFlag),
      .fpOtherExceptionTrap(fpOtherExceptionTrap),
      .fpTrapTypeField(fpTrapTypeField));

   fprf_pipe_model i_fprf_pipe_model (.rdAEn(rdAEn), .rdASize(rdASize),
      .rdAField(rdAField), .rdBEn(rdBEn), .rdBSize(rdBSize),
      .rdBField(rdBField), .wrEn(wrEn), .wrSize(wrSize),
      .wrField(wrField), .wrData(wrData), .issueValid(issueValid),
      .issueSize(issueSize), .issueField(issueField),
      .clrUpperDirty(clrUpperDirty), .clrLowerDirty(clrLowerDirty));

   ////////////////////////////////////////
   // reference model: 64 words carry every alias view
   function automatic logic [5:0] num(fprf_size_e s, logic [4:0] f);
      case (s)
         FPRF_SZ_DOUBLE: num = {f[0], f[4:1], 1'b0};
         FPRF_SZ_QUAD:   num = {f[0], f[4:2], 2'b00};
         default:        num = {1'b0, f};
      endcase
   endfunction

   function automatic logic [127:0] view(fprf_size_e s, logic [4:0] f);
      logic [5:0] n;
      n = num(s, f);
      case (s)
         FPRF_SZ_SINGLE: view = {96'h0, mw[n]};
         FPRF_SZ_DOUBLE: view = {64'h0, mw[n], mw[n+1]};
         FPRF_SZ_QUAD:   view = {mw[n], mw[n+1], mw[n+2], mw[n+3]};
         default:        view = '0;
      endcase
   endfunction

   // which half a single or double write or issue marks dirty
   function automatic logic [1:0] dirt(logic e, fprf_size_e s,
                                       logic [4:0] f);
      logic [5:0] n;
      n = num(s, f);
      if (!e || s == FPRF_SZ_QUAD || s == FPRF_SZ_RSVD) return 2'b00;
      return {n[5], !n[5]};
   endfunction

   // one clock edge of the model; reads see storage before the write
   task automatic step();
      logic [5:0] n;
      logic [1:0] d;
      n = num(wrSize, wrField);
      d = dirt(wrEn, wrSize, wrField) | dirt(issueValid, issueSize,
                                             issueField);
      mTrap = (rdAEn && rdASize == FPRF_SZ_QUAD)
         || (rdBEn && rdBSize == FPRF_SZ_QUAD)
         || (wrEn && wrSize == FPRF_SZ_QUAD)
         || (issueValid && issueSize == FPRF_SZ_QUAD);
      if (mTrap) mCode = `FPRF_FTT_QUAD_EMU;
      if (rdAEn) mA = view(rdASize, rdAField);
      if (rdBEn) mB = view(rdBSize, rdBField);
      mU = d[1] | (mU & !clrUpperDirty);
      mL = d[0] | (mL & !clrLowerDirty);
      if (wrEn && wrSize == FPRF_SZ_SINGLE) mw[n] = wrData[31:0];
      if (wrEn && wrSize == FPRF_SZ_DOUBLE) begin
         mw[n] = wrData[63:32];
         mw[n+1] = wrData[31:0];
      end
   endtask

   ////////////////////////////////////////
   task automatic stopTest();
      $display("comparisons=%0d mismatches=%0d", comparisons, errTotal);
      if (errTotal == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // watchdog: twice the expected run length
   initial begin
      #(8 * (NOPS + 10));
      errTotal++;
      stopTest();
   end

   // reset state, then random traffic against the model every cycle
   initial begin
      resetn = 1'b0;
      foreach (mw[k]) mw[k] = '0;
      {mA, mB, mCode, mU, mL, mTrap} = '0;
      repeat (2) @(posedge clk_sys);
      #1 resetn = 1'b1;
      `CHK({rdAData, rdBData}, 256'h0)
      `CHK({upperDirtyFlag, lowerDirtyFlag, fpTrapTypeField}, 5'h0)
      $display("test reset done");
      for (int i = 0; i < NOPS; i++) begin
         i_fprf_pipe_model.randOp();
         @(posedge clk_sys);
         step();
         #1;
         `CHK(rdAData, mA)
         `CHK(rdBData, mB)
         `CHK(upperDirtyFlag, mU)
         `CHK(lowerDirtyFlag, mL)
         `CHK(fpOtherExceptionTrap, mTrap)
         `CHK(fpTrapTypeField, mCode)
      end
      $display("test random done");
      stopTest();
   end
endmodule // test_fprf_regfile
